// ### verilog/cag_arming.sv
// cag_arming.sv: arming machine and gate-time control over axi4-lite
// assumes: one 50 mhz clock, synchronous active-low reset, external pins asynchronous
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "cag_cfg.svh"
module cag_arming (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [11:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [2:0] s_axi_awprot_in,
    input wire logic [2:0] s_axi_arprot_in,
    input wire logic ext_arm_in,
    input wire logic rear_trigger_source_in,
    input wire logic meas_signal_in,
    output logic [1:0] arm_level_sel_out,
    output logic arm_slope_neg_out,
    output logic auto_level_out,
    output logic input_sel_out,
    output logic busy_out
);
    import cag_pkg::*;
    localparam logic [15:0] CYC_MS = 16'(`CAG_CYC_PER_MS - 1);

    cag_regs_t r;
    cag_regs_t next_r;
    logic do_write;
    logic bus_cmd;
    logic cmd_init, cmd_abort, cmd_reset, cmd_arm, cmd_trg, cmd_res;
    logic arm_edge, rear_edge, sig_edge;
    logic start_ok, stop_ok;
    logic gated_fn, avg_ok;
    logic [31:0] rd;

    // =========================================================
    // source qualification
    function automatic logic src_hit(input cag_src_t s, input logic imm, input logic trg,
                                     input logic fe, input logic re);
        unique case (s)
            CAG_SRC_IMMEDIATE: src_hit = 1'b1;
            CAG_SRC_HOLD: src_hit = imm;
            CAG_SRC_BUS: src_hit = trg | imm;
            CAG_SRC_EXTERNAL: src_hit = fe | imm;
            CAG_SRC_REAR: src_hit = re | imm;
            default: src_hit = 1'b0;
        endcase
    endfunction

    // resolution digits to gate ms
    function automatic logic [16:0] digits_to_ms(input logic [3:0] d);
        if (d >= 4'h9) begin
            digits_to_ms = 17'h003e8;
        end else if (d == 4'h8) begin
            digits_to_ms = 17'h00064;
        end else if (d == 4'h7) begin
            digits_to_ms = 17'h0000a;
        end else begin
            digits_to_ms = `CAG_GATE_MIN_MS;
        end
    endfunction

    // =========================================================
    // combinational next state
    always_comb begin
        next_r = r;
        do_write = r.bus.aw_ok & r.bus.w_ok & ~r.bus.bvalid;
        bus_cmd = do_write & (r.bus.awaddr == `CAG_CMD_OFF) & r.bus.wstrb[0];
        cmd_init = bus_cmd & r.bus.wdata[`CAG_CMD_INIT_BIT];
        cmd_abort = bus_cmd & r.bus.wdata[`CAG_CMD_ABORT_BIT];
        cmd_reset = bus_cmd & r.bus.wdata[`CAG_CMD_RESET_BIT];
        cmd_arm = bus_cmd & r.bus.wdata[`CAG_CMD_ARM_BIT];
        cmd_trg = bus_cmd & r.bus.wdata[`CAG_CMD_TRG_BIT];
        cmd_res = bus_cmd & r.bus.wdata[`CAG_CMD_RES_BIT];
        arm_edge = r.cfg.slope_neg ? (r.arm_sync[2] & ~r.arm_sync[1])
                                   : (~r.arm_sync[2] & r.arm_sync[1]);
        rear_edge = ~r.rear_sync[2] & r.rear_sync[1];
        sig_edge = ~r.sig_sync[2] & r.sig_sync[1];
        start_ok = src_hit(r.cfg.start_src, r.arm_pend, r.trg_pend, arm_edge, rear_edge);
        stop_ok = src_hit(r.cfg.stop_src, r.arm_pend, r.trg_pend, arm_edge, rear_edge);
        gated_fn = (r.cfg.func == CAG_FN_FREQUENCY) | (r.cfg.func == CAG_FN_PERIOD)
                 | (r.cfg.func == CAG_FN_FUNCTION_A);
        avg_ok = r.cfg.avg_en & ~((r.cfg.func == CAG_FN_TOTALIZE) | (r.cfg.func == CAG_FN_AC)
                 | (r.cfg.func == CAG_FN_DC) | (r.cfg.func == CAG_FN_MIN)
                 | (r.cfg.func == CAG_FN_MAX));
        next_r.arm_sync = {r.arm_sync[1:0], ext_arm_in};
        next_r.rear_sync = {r.rear_sync[1:0], rear_trigger_source_in};
        next_r.sig_sync = {r.sig_sync[1:0], meas_signal_in};
        // one-shot and bus trigger latch until consumed
        next_r.arm_pend = r.arm_pend | cmd_arm;
        next_r.trg_pend = r.trg_pend | cmd_trg;

        // ---------- axi4-lite slave
        if (s_axi_awvalid_in & ~r.bus.aw_ok) begin
            next_r.bus.aw_ok = 1'b1;
            next_r.bus.awaddr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in & ~r.bus.w_ok) begin
            next_r.bus.w_ok = 1'b1;
            next_r.bus.wdata = s_axi_wdata_in;
            next_r.bus.wstrb = s_axi_wstrb_in;
        end
        if (do_write) begin
            next_r.bus.bvalid = 1'b1;
            next_r.bus.bresp = 2'b00;
            unique case (r.bus.awaddr)
                `CAG_CTRL_OFF: begin
                    if (r.state == CAG_IDLE) begin
                        next_r.cfg.func = cag_func_t'(r.bus.wdata[`CAG_CTRL_FUNC_LSB +: 4]);
                        next_r.cfg.input_sel = r.bus.wdata[`CAG_CTRL_INPUT_BIT];
                        next_r.cfg.auto_level = r.bus.wdata[`CAG_CTRL_AUTO_BIT];
                        next_r.cfg.continuous_initiation = r.bus.wdata[`CAG_CTRL_CONT_BIT];
                        next_r.cfg.avg_en = r.bus.wdata[`CAG_CTRL_AVG_BIT];
                    end else begin
                        next_r.bus.bresp = 2'b10;
                    end
                end
                `CAG_ARM_OFF: begin
                    if (r.state == CAG_IDLE) begin
                        next_r.cfg.start_src = cag_src_t'(r.bus.wdata[`CAG_ARM_START_LSB +: 3]);
                        next_r.cfg.stop_src = cag_src_t'(r.bus.wdata[`CAG_ARM_STOP_LSB +: 3]);
                        next_r.cfg.slope_neg = r.bus.wdata[`CAG_ARM_SLOPE_BIT];
                        next_r.cfg.level = cag_level_t'(r.bus.wdata[`CAG_ARM_LEVEL_LSB +: 2]);
                    end else begin
                        next_r.bus.bresp = 2'b10;
                    end
                end
                `CAG_GATE_OFF: begin
                    if (r.state == CAG_IDLE && r.bus.wdata[16:0] >= `CAG_GATE_MIN_MS
                        && r.bus.wdata[16:0] <= `CAG_GATE_MAX_MS) begin
                        next_r.cfg.gate_ms = r.bus.wdata[16:0];
                    end else begin
                        next_r.bus.bresp = 2'b10;
                    end
                end
                `CAG_CMD_OFF: begin
                    if (cmd_res & (r.state == CAG_IDLE)) begin
                        next_r.cfg.gate_ms = digits_to_ms(r.bus.wdata[`CAG_CMD_DIGITS_LSB +: 4]);
                    end
                end
                default: next_r.bus.bresp = 2'b10;
            endcase
        end
        if (r.bus.bvalid & s_axi_bready_in) begin
            next_r.bus.bvalid = 1'b0;
            next_r.bus.aw_ok = 1'b0;
            next_r.bus.w_ok = 1'b0;
        end
        if (s_axi_arvalid_in & ~r.bus.rvalid) begin
            next_r.bus.rvalid = 1'b1;
            next_r.bus.rresp = 2'b00;
            rd = 32'h0;
            unique case (s_axi_araddr_in)
                `CAG_CTRL_OFF: rd = {24'h0, r.cfg.avg_en, r.cfg.continuous_initiation,
                                     r.cfg.auto_level, r.cfg.input_sel, r.cfg.func};
                `CAG_ARM_OFF: rd = {21'h0, r.cfg.level, r.cfg.slope_neg, 1'b0,
                                    r.cfg.stop_src, 1'b0, r.cfg.start_src};
                `CAG_GATE_OFF: rd = {15'h0, r.cfg.gate_ms};
                `CAG_CMD_OFF: rd = 32'h0;
                `CAG_STAT_OFF: rd = {25'h0, r.avg_n[3:0], r.done, r.phase[0], r.state};
                `CAG_RESULT_OFF: rd = r.result;
                `CAG_COUNT_OFF: rd = {25'h0, r.avg_n};
                default: next_r.bus.rresp = 2'b10;
            endcase
            next_r.bus.rdata = rd;
        end else begin
            rd = 32'h0;
        end
        if (r.bus.rvalid & s_axi_rready_in) begin
            next_r.bus.rvalid = 1'b0;
        end

        // ---------- arming machine
        unique case (r.state)
            CAG_IDLE: begin
                next_r.phase = CAG_PH_ARMWAIT;
                if (r.cfg.continuous_initiation | cmd_init) begin
                    next_r.state = CAG_WAIT_ARM;
                    next_r.acc = 32'h0;
                    next_r.sum = 39'h0;
                    next_r.avg_n = 7'h0;
                    next_r.done = 1'b0;
                end
            end
            CAG_WAIT_ARM: begin
                unique case (r.phase)
                    CAG_PH_ARMWAIT: if (start_ok) begin
                        next_r.phase = CAG_PH_EDGEWAIT;
                        next_r.arm_pend = cmd_arm;
                        next_r.trg_pend = cmd_trg;
                    end
                    CAG_PH_EDGEWAIT: if (sig_edge) begin
                        next_r.phase = CAG_PH_GATING;
                        next_r.cyc = 16'h0;
                        next_r.ms = 17'h0;
                        next_r.acc = 32'h0;
                    end
                    CAG_PH_GATING: begin
                        if (sig_edge) next_r.acc = r.acc + 32'h1;
                        // gate timer counts only for gated functions
                        if (gated_fn) begin
                            next_r.cyc = (r.cyc == CYC_MS) ? 16'h0 : r.cyc + 16'h1;
                            if (r.cyc == CYC_MS) next_r.ms = r.ms + 17'h1;
                        end
                        // totalize never closes by itself
                        if (r.cfg.func != CAG_FN_TOTALIZE) begin
                            if ((!gated_fn || r.ms >= r.cfg.gate_ms) && stop_ok) begin
                                next_r.phase = CAG_PH_STOPEDGE;
                                next_r.arm_pend = cmd_arm;
                                next_r.trg_pend = cmd_trg;
                            end
                        end
                    end
                    CAG_PH_STOPEDGE: if (sig_edge) begin
                        if (avg_ok) begin
                            next_r.sum = r.sum + {7'h0, r.acc};
                            next_r.avg_n = r.avg_n + 7'h1;
                            if (r.avg_n == `CAG_AVG_COUNT - 7'h1) begin
                                next_r.result = 32'((r.sum + {7'h0, r.acc}) / 39'd100);
                                next_r.done = 1'b1;
                                next_r.state = CAG_IDLE;
                            end else begin
                                next_r.phase = CAG_PH_ARMWAIT;
                            end
                        end else begin
                            next_r.result = r.acc;
                            next_r.done = 1'b1;
                            next_r.state = CAG_IDLE;
                        end
                    end
                endcase
            end
        endcase
        if (cmd_abort | cmd_reset) begin
            next_r.state = CAG_IDLE;
            next_r.phase = CAG_PH_ARMWAIT;
            next_r.acc = 32'h0;
            next_r.sum = 39'h0;
            next_r.avg_n = 7'h0;
            next_r.arm_pend = 1'b0;
            next_r.trg_pend = 1'b0;
            next_r.cfg.continuous_initiation = r.cfg.continuous_initiation & ~cmd_reset;
        end
    end

    // =========================================================
    // state register
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            r <= '0;
            r.cfg.func <= CAG_FN_FREQUENCY;
            r.cfg.gate_ms <= `CAG_GATE_RST_MS;
            r.cfg.start_src <= CAG_SRC_IMMEDIATE;
            r.cfg.stop_src <= CAG_SRC_IMMEDIATE;
        end else begin
            r <= next_r;
        end
    end

    // =========================================================
    // outputs
    assign s_axi_awready_out = ~r.bus.aw_ok;
    assign s_axi_wready_out = ~r.bus.w_ok;
    assign s_axi_bvalid_out = r.bus.bvalid;
    assign s_axi_bresp_out = r.bus.bresp;
    assign s_axi_arready_out = ~r.bus.rvalid;
    assign s_axi_rvalid_out = r.bus.rvalid;
    assign s_axi_rdata_out = r.bus.rdata;
    assign s_axi_rresp_out = r.bus.rresp;
    assign arm_level_sel_out = r.cfg.level;
    assign arm_slope_neg_out = r.cfg.slope_neg;
    assign auto_level_out = r.cfg.auto_level;
    assign input_sel_out = r.cfg.input_sel;
    assign busy_out = (r.state == CAG_WAIT_ARM);
endmodule // cag_arming

// ### verilog/cag_cfg.svh
// cag_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by the arming block, the assertions and the testbench
`ifndef CAG_CFG_SVH
`define CAG_CFG_SVH
// register byte offsets
`define CAG_CTRL_OFF 12'h000
`define CAG_ARM_OFF 12'h004
`define CAG_GATE_OFF 12'h008
`define CAG_CMD_OFF 12'h00c
`define CAG_STAT_OFF 12'h010
`define CAG_RESULT_OFF 12'h014
`define CAG_COUNT_OFF 12'h018
// ctrl fields
`define CAG_CTRL_FUNC_LSB 0
`define CAG_CTRL_INPUT_BIT 4
`define CAG_CTRL_AUTO_BIT 5
`define CAG_CTRL_CONT_BIT 6
`define CAG_CTRL_AVG_BIT 7
// arm fields
`define CAG_ARM_START_LSB 0
`define CAG_ARM_STOP_LSB 4
`define CAG_ARM_SLOPE_BIT 8
`define CAG_ARM_LEVEL_LSB 9
// command bits
`define CAG_CMD_INIT_BIT 0
`define CAG_CMD_ABORT_BIT 1
`define CAG_CMD_RESET_BIT 2
`define CAG_CMD_ARM_BIT 3
`define CAG_CMD_TRG_BIT 4
`define CAG_CMD_RES_BIT 5
`define CAG_CMD_DIGITS_LSB 8
// timing
`define CAG_CLK_HZ 50000000
`define CAG_GATE_UNIT_MS 1
`define CAG_CYC_PER_MS (`CAG_CLK_HZ / 1000 * `CAG_GATE_UNIT_MS)
`define CAG_GATE_MIN_MS 17'h00001
`define CAG_GATE_MAX_MS 17'h1869f
`define CAG_GATE_RST_MS 17'h00064
`define CAG_AVG_COUNT 7'h64
`endif

// ### verilog/cag_pkg.sv
// cag_pkg.sv: types of the counter arming and gating block
// assumes: nothing beyond the cfg header
package cag_pkg;
    typedef enum logic [0:0] {
        CAG_IDLE = 1'b0,
        CAG_WAIT_ARM = 1'b1
    } cag_state_t;
    typedef enum logic [2:0] {
        CAG_SRC_IMMEDIATE = 3'b000,
        CAG_SRC_HOLD = 3'b001,
        CAG_SRC_BUS = 3'b010,
        CAG_SRC_EXTERNAL = 3'b011,
        CAG_SRC_REAR = 3'b100
    } cag_src_t;
    typedef enum logic [3:0] {
        CAG_FN_FREQUENCY = 4'h0,
        CAG_FN_PERIOD = 4'h1,
        CAG_FN_FUNCTION_A = 4'h2,
        CAG_FN_TINT = 4'h3,
        CAG_FN_TOTALIZE = 4'h4,
        CAG_FN_AC = 4'h5,
        CAG_FN_DC = 4'h6,
        CAG_FN_MIN = 4'h7,
        CAG_FN_MAX = 4'h8
    } cag_func_t;
    typedef enum logic [1:0] {
        CAG_LVL_TTL = 2'b00,
        CAG_LVL_ECL = 2'b01,
        CAG_LVL_GND = 2'b10
    } cag_level_t;
    typedef enum logic [1:0] {
        CAG_PH_ARMWAIT = 2'b00,
        CAG_PH_EDGEWAIT = 2'b01,
        CAG_PH_GATING = 2'b10,
        CAG_PH_STOPEDGE = 2'b11
    } cag_phase_t;
    typedef struct packed {
        logic aw_ok;
        logic w_ok;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cag_bus_t;
    typedef struct packed {
        cag_func_t func;
        logic input_sel;
        logic auto_level;
        logic continuous_initiation;
        logic avg_en;
        cag_src_t start_src;
        cag_src_t stop_src;
        logic slope_neg;
        cag_level_t level;
        logic [16:0] gate_ms;
    } cag_cfg_t;
    typedef struct packed {
        cag_state_t state;
        cag_phase_t phase;
        logic [15:0] cyc;
        logic [16:0] ms;
        logic [31:0] acc;
        logic [38:0] sum;
        logic [6:0] avg_n;
        logic [31:0] result;
        logic done;
        logic [2:0] arm_sync;
        logic [2:0] rear_sync;
        logic [2:0] sig_sync;
        logic arm_pend;
        logic trg_pend;
        cag_bus_t bus;
        cag_cfg_t cfg;
    } cag_regs_t;
endpackage

// ### bench/cag_arming_assertions.sv
// cag_arming_assertions.sv: port checks of the arming block
// assumes: bound to cag_arming, one clock, sync active-low reset
`timescale 1ns/1ps
`include "cag_cfg.svh"
module cag_arming_assertions (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [1:0] arm_level_sel_out,
    input wire logic arm_slope_neg_out,
    input wire logic auto_level_out,
    input wire logic input_sel_out,
    input wire logic busy_out
);
    // ==========
    // checks
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    wire aw_hs = s_axi_awvalid_in && s_axi_awready_out;
    wire w_hs = s_axi_wvalid_in && s_axi_wready_out;
    a_write_answer: assert property (aw_hs && w_hs |-> ##2 s_axi_bvalid_out)
        else $error("no write response after address and data");
    a_aw_slot: assert property (aw_hs |=> !s_axi_awready_out)
        else $error("awready stayed high after capture");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("no read data after address");
    a_rvalid_drop: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
        else $error("rvalid held after rready");
    a_resp_codes: assert property (s_axi_bvalid_out |-> s_axi_bresp_out inside {2'b00, 2'b10})
        else $error("bad write response code");
    a_reset_state: assert property ($rose(rst_n_in) |-> !busy_out && arm_level_sel_out == 2'b00
        && !arm_slope_neg_out && !auto_level_out && !input_sel_out)
        else $error("outputs not at reset values");
    a_level_code: assert property (arm_level_sel_out != 2'b11)
        else $error("threshold code out of range");
    a_cfg_frozen: assert property (busy_out && $past(busy_out) |->
        $stable({arm_level_sel_out, arm_slope_neg_out, auto_level_out, input_sel_out}))
        else $error("configuration changed while armed");
    a_reset_cmd: assert property (aw_hs && w_hs && s_axi_awaddr_in == `CAG_CMD_OFF
        && s_axi_wdata_in[`CAG_CMD_RESET_BIT] |-> ##[1:4] !busy_out)
        else $error("reset command left machine busy");
endmodule // cag_arming_assertions
bind cag_arming cag_arming_assertions u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
    .arm_level_sel_out(arm_level_sel_out), .arm_slope_neg_out(arm_slope_neg_out),
    .auto_level_out(auto_level_out), .input_sel_out(input_sel_out), .busy_out(busy_out));

// ### bench/cag_ext_model.sv
// cag_ext_model.sv: outside equipment on the counter pins
// assumes: bench clock, event train gated by en_in, arm pulses on request
`timescale 1ns/1ps
module cag_ext_model (
    input wire logic mclk_in,
    input wire logic en_in,
    input wire logic fire_arm_in,
    input wire logic fire_rear_in,
    input wire logic slope_neg_in,
    output logic meas_out,
    output logic arm_out,
    output logic rear_out
);
    logic [4:0] div = 5'h00;
    logic [2:0] arm_n = 3'h0;
    logic [2:0] rear_n = 3'h0;
    logic sq = 1'b0;
    // ==========
    // events every 40 cycles, 4-cycle arm pulses
    always @(posedge mclk_in) begin
        div <= (div == 5'h13) ? 5'h00 : div + 5'h01;
        if (div == 5'h13) begin
            sq <= !sq;
        end
        arm_n <= fire_arm_in ? 3'h4 : arm_n - {2'b00, arm_n != 3'h0};
        rear_n <= fire_rear_in ? 3'h4 : rear_n - {2'b00, rear_n != 3'h0};
    end
    assign meas_out = en_in && sq;
    assign arm_out = (arm_n != 3'h0) ^ slope_neg_in;
    assign rear_out = rear_n != 3'h0;
endmodule // cag_ext_model

// ### bench/cag_arming_tb.sv
// cag_arming_tb.sv: register-level tests of the arming block
// assumes: 50 mhz clock, bready/rready held high
`timescale 1ns/1ps
`include "cag_cfg.svh"
module cag_arming_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic awv = 1'b0;
    logic wv = 1'b0;
    logic arv = 1'b0;
    logic fa = 1'b0;
    logic fr = 1'b0;
    logic en = 1'b0;
    logic [11:0] awa = 12'h000;
    logic [11:0] ara = 12'h000;
    logic [31:0] wd = 32'h00000000;
    logic awr, wrd, bv, arr, rv, slp, aut, isel, busy, meas, earm, rear;
    logic [1:0] br, rrsp, lvl, r;
    logic [31:0] rdat, res, v;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    int i;
    int dig [6] = '{3, 5, 6, 7, 8, 9};
    logic [31:0] gt [6] = '{1, 1, 1, 10, 100, 1000};
    cag_arming u_dut (.mclk_in(mclk), .rst_n_in(rst_n), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wrd), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(1'b1),
        .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
        .s_axi_rresp_out(rrsp), .s_axi_rvalid_out(rv), .s_axi_rready_in(1'b1), .s_axi_awprot_in(3'h0),
        .s_axi_arprot_in(3'h0), .ext_arm_in(earm), .rear_trigger_source_in(rear), .meas_signal_in(meas),
        .arm_level_sel_out(lvl), .arm_slope_neg_out(slp), .auto_level_out(aut), .input_sel_out(isel),
        .busy_out(busy));
    cag_ext_model u_ext (.mclk_in(mclk), .en_in(en), .fire_arm_in(fa), .fire_rear_in(fr),
        .slope_neg_in(slp), .meas_out(meas), .arm_out(earm), .rear_out(rear));
    // ==========
    // clock, timeout, report
    initial begin
        forever #10 mclk = !mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_total++;
            close_out;
        end
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_rng(input string n, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
        checked++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            err_total++;
            $display("Error %s expected %0d to %0d seen %h", n, lo, hi, g);
        end
    endtask
    // ==========
    // bus tasks
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] q);
        logic ha, hw, hb;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        forever begin
            @(negedge mclk);
            ha = awr && awv;
            hw = wrd && wv;
            hb = bv;
            q = br;
            @(posedge mclk);
            if (ha) awv <= 1'b0;
            if (hw) wv <= 1'b0;
            if (hb) break;
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] q);
        logic ha, hr;
        ara <= a;
        arv <= 1'b1;
        forever begin
            @(negedge mclk);
            ha = arr && arv;
            hr = rv;
            d = rdat;
            q = rrsp;
            @(posedge mclk);
            if (ha) arv <= 1'b0;
            if (hr) break;
        end
    endtask
    task automatic wrc(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        wr(a, d, r);
        chk($sformatf("bresp %h", a), e, r);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        rd(a, v, r);
        chk($sformatf("reg %h", a), e, v);
    endtask
    task automatic wait_busy(input logic e, input int n);
        int k;
        for (k = 0; k < n; k++) begin
            @(negedge mclk);
            if (busy === e) break;
        end
        chk("busy", e, busy);
        @(posedge mclk);
    endtask
    // ==========
    // tests
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rdc(`CAG_CTRL_OFF, 32'h0);
        rdc(`CAG_GATE_OFF, 32'd100);
        rdc(`CAG_CMD_OFF, 32'h0);
        rd(12'h020, v, r);
        chk("unmapped resp", 2'b10, r);
        wrc(`CAG_GATE_OFF, 32'h1869f, 2'b00);
        rdc(`CAG_GATE_OFF, 32'h1869f);
        for (i = 0; i < 6; i++) begin
            wrc(`CAG_CMD_OFF, (dig[i] << `CAG_CMD_DIGITS_LSB) | 32'h20, 2'b00);
            rdc(`CAG_GATE_OFF, gt[i]);
        end
        wrc(`CAG_GATE_OFF, 32'd1, 2'b00);
        rdc(`CAG_GATE_OFF, 32'd1);
        // bus trigger start, full 1 ms gate
        wrc(`CAG_ARM_OFF, 32'h2, 2'b00);
        wrc(`CAG_CMD_OFF, 32'h1, 2'b00);
        wait_busy(1'b1, 10);
        repeat (100) @(posedge mclk);
        rdc(`CAG_STAT_OFF, 32'h1);
        wrc(`CAG_CMD_OFF, 32'h10, 2'b00);
        repeat (5) @(posedge mclk);
        rdc(`CAG_STAT_OFF, 32'h3);
        en <= 1'b1;
        wait_busy(1'b0, 60000);
        rdc(`CAG_STAT_OFF, 32'h4);
        rd(`CAG_RESULT_OFF, res, r);
        chk_rng("result", 32'd1249, 32'd1251, res);
        en <= 1'b0;
        // hold, refused config, one-shot, abort
        wrc(`CAG_ARM_OFF, 32'h1, 2'b00);
        wrc(`CAG_CMD_OFF, 32'h1, 2'b00);
        repeat (100) @(posedge mclk);
        rdc(`CAG_STAT_OFF, 32'h1);
        wrc(`CAG_CTRL_OFF, 32'h4, 2'b10);
        rdc(`CAG_CTRL_OFF, 32'h0);
        wrc(`CAG_CMD_OFF, 32'h8, 2'b00);
        repeat (5) @(posedge mclk);
        rdc(`CAG_STAT_OFF, 32'h3);
        wrc(`CAG_CMD_OFF, 32'h2, 2'b00);
        wait_busy(1'b0, 10);
        rdc(`CAG_RESULT_OFF, res);
        // front and rear arm inputs
        for (i = 3; i < 5; i++) begin
            wrc(`CAG_ARM_OFF, i | ((i - 2) << 9) | 32'h100, 2'b00);
            chk("level", i - 2, lvl);
            chk("slope", 1'b1, slp);
            wrc(`CAG_CMD_OFF, 32'h1, 2'b00);
            repeat (50) @(posedge mclk);
            rdc(`CAG_STAT_OFF, 32'h1);
            fa <= (i == 3);
            fr <= (i == 4);
            @(posedge mclk);
            fa <= 1'b0;
            fr <= 1'b0;
            repeat (10) @(posedge mclk);
            rdc(`CAG_STAT_OFF, 32'h3);
            wrc(`CAG_CMD_OFF, 32'h2, 2'b00);
            wait_busy(1'b0, 10);
        end
        // totalize never ends by itself
        wrc(`CAG_ARM_OFF, 32'h0, 2'b00);
        wrc(`CAG_CTRL_OFF, 32'h34, 2'b00);
        chk("auto", 1'b1, aut);
        chk("input", 1'b1, isel);
        en <= 1'b1;
        wrc(`CAG_CMD_OFF, 32'h1, 2'b00);
        repeat (2000) @(posedge mclk);
        wait_busy(1'b1, 1);
        wrc(`CAG_CMD_OFF, 32'h2, 2'b00);
        wait_busy(1'b0, 10);
        // averaging on an ungated function, then refused averaging
        wrc(`CAG_CTRL_OFF, 32'h83, 2'b00);
        wrc(`CAG_CMD_OFF, 32'h1, 2'b00);
        wait_busy(1'b0, 12000);
        rdc(`CAG_COUNT_OFF, 32'd100);
        wrc(`CAG_CTRL_OFF, 32'h85, 2'b00);
        wrc(`CAG_CMD_OFF, 32'h1, 2'b00);
        wait_busy(1'b0, 200);
        rdc(`CAG_COUNT_OFF, 32'h0);
        en <= 1'b0;
        // continuous initiation, reset command
        wrc(`CAG_CTRL_OFF, 32'h40, 2'b00);
        wait_busy(1'b1, 10);
        wrc(`CAG_CMD_OFF, 32'h4, 2'b00);
        wait_busy(1'b0, 10);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rdc(`CAG_GATE_OFF, 32'd100);
        close_out;
    end
endmodule // cag_arming_tb
